// ===== sysbus_flow.sv
// processor-side transaction logic of the multiplexed system bus
`timescale 1ns/100ps
module sysbus_flow
  import sysbus_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // multiplexed bus, split into in/out/enable
  input wire logic [sysbus_pkg::AD_W-1:0] addr_data_bus_i,
  output logic [sysbus_pkg::AD_W-1:0] addr_data_bus_o,
  output logic addr_data_bus_oe_o,
  input wire logic [sysbus_pkg::CMD_W-1:0] command_bus_i,
  output logic [sysbus_pkg::CMD_W-1:0] command_bus_o,
  output logic command_bus_oe_o,
  // handshake pins
  output logic proc_valid_n_o,
  output logic proc_owns_bus_n_o,
  output logic proc_bus_request_n_o,
  input wire logic agent_valid_n_i,
  input wire logic agent_ready_n_i,
  input wire logic agent_bus_request_n_i,
  // configuration
  input wire logic proc_tx_rate_field_i,
  // processor request port
  input wire logic req_valid_i,
  input wire logic [3:0] req_cmd_i,
  input wire logic [sysbus_pkg::AD_W-1:0] req_addr_i,
  output logic req_ack_o,
  // outgoing write data
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [sysbus_pkg::AD_W-1:0] wr_data_i,
  // read response out
  output logic rsp_valid_o,
  output logic [sysbus_pkg::AD_W-1:0] rsp_data_o,
  output logic rsp_last_o,
  output logic bus_error_o,
  // interrupt write out
  output logic intr_write_o,
  output logic [sysbus_pkg::AD_W-1:0] intr_data_o
);
  import sysbus_pkg::*;

  typedef struct packed {
    bus_state_t state;
    logic rdy_prev;
    logic rd_pend;
    logic wr_pend;
    logic err;
    logic [CNT_W-1:0] cnt;
    logic [1:0] gap;
    logic [AD_W-1:0] ad;
    logic ad_oe;
    logic [CMD_W-1:0] cmd;
    logic cmd_oe;
    logic proc_valid_n_n;
    logic owns_n;
    logic proc_bus_request_n_n;
    logic ack;
    logic rsp_v;
    logic [AD_W-1:0] rsp_d;
    logic rsp_last;
    logic berr;
    logic iwr;
    logic [AD_W-1:0] idata;
  } flow_t;

  flow_t s_r, s_nxt;
  logic rdy, dcyc, acyc, last, pop;
  logic wq_valid;
  logic [AD_W-1:0] wq_data;

  function automatic logic [CNT_W-1:0] words_of(input logic [3:0] c);
    if (!c[CMD_BLOCK_BIT]) begin
      return WORDS_1;
    end else if (c[1:0] == BLK_2) begin
      return WORDS_2;
    end else if (c[1:0] == BLK_4) begin
      return WORDS_4;
    end
    return WORDS_8;
  endfunction

  // write data is staged in a fifo; the rate pattern stalls whenever the fifo runs empty
  word_fifo #(.WIDTH(AD_W), .DEPTH(FIFO_DEPTH)) wq (
    .clk_i(mclk_i),
    .rst_i(reset_i),
    .in_valid_i(wr_valid_i),
    .in_ready_o(wr_ready_o),
    .in_data_i(wr_data_i),
    .out_valid_o(wq_valid),
    .out_ready_i(pop),
    .out_data_o(wq_data)
  );

  assign rdy = !agent_ready_n_i;
  assign dcyc = !agent_valid_n_i && command_bus_i[CMD_DATA_BIT];
  assign acyc = !agent_valid_n_i && !command_bus_i[CMD_DATA_BIT];
  assign last = !command_bus_i[ID_MORE_BIT];
  assign pop = (s_r.state == ST_WDATA) && (s_r.gap == NO_IDLE) && (s_r.cnt != '0)
    && wq_valid;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdy_prev = rdy;
    s_nxt.ack = 1'b0;
    s_nxt.rsp_v = 1'b0;
    s_nxt.berr = 1'b0;
    s_nxt.iwr = 1'b0;
    s_nxt.proc_bus_request_n_n = 1'b1;
    case (s_r.state)
      ST_MASTER: begin
        if (!agent_bus_request_n_i) begin
          s_nxt.state = ST_SLAVE;
          s_nxt.owns_n = 1'b1;
          s_nxt.ad_oe = 1'b0;
          s_nxt.cmd_oe = 1'b0;
          s_nxt.proc_valid_n_n = 1'b1;
        end else if (req_valid_i && !s_r.rd_pend) begin
          s_nxt.state = ST_ADDR;
          s_nxt.ad = req_addr_i;
          s_nxt.cmd = {1'b0, req_cmd_i};
          s_nxt.proc_valid_n_n = 1'b0;
          s_nxt.cnt = words_of(req_cmd_i);
        end
      end
      ST_ADDR: begin
        if (s_r.rdy_prev && rdy) begin
          s_nxt.ack = 1'b1;
          s_nxt.proc_valid_n_n = 1'b1;
          if (s_r.cmd[CMD_WRITE_BIT]) begin
            s_nxt.state = ST_WDATA;
            s_nxt.gap = NO_IDLE;
          end else begin
            // read issued: hand the bus over for the response
            s_nxt.state = ST_SLAVE;
            s_nxt.rd_pend = 1'b1;
            s_nxt.owns_n = 1'b1;
            s_nxt.ad_oe = 1'b0;
            s_nxt.cmd_oe = 1'b0;
          end
        end else if (!agent_bus_request_n_i && !rdy) begin
          // killed or held off while the agent wants the bus; retried later
          s_nxt.state = ST_SLAVE;
          s_nxt.owns_n = 1'b1;
          s_nxt.ad_oe = 1'b0;
          s_nxt.cmd_oe = 1'b0;
          s_nxt.proc_valid_n_n = 1'b1;
        end
        // otherwise the same address cycle repeats
      end
      ST_WDATA: begin
        s_nxt.proc_valid_n_n = 1'b1; // idle cycles keep the old data
        if (s_r.gap != NO_IDLE) begin
          s_nxt.gap = 2'(s_r.gap - ONE2);
        end else if (s_r.cnt == '0) begin
          s_nxt.state = ST_MASTER;
        end else if (wq_valid) begin
          s_nxt.ad = wq_data;
          s_nxt.cmd = (s_r.cnt == WORDS_1) ? ID_LAST : ID_MORE;
          s_nxt.proc_valid_n_n = 1'b0;
          s_nxt.cnt = CNT_W'(s_r.cnt - WORDS_1);
          s_nxt.gap = (proc_tx_rate_field_i == RATE_DXX) ? DXX_IDLE : NO_IDLE;
        end
      end
      ST_SLAVE: begin
        // own request while the agent keeps the bus
        s_nxt.proc_bus_request_n_n = !(req_valid_i && !agent_bus_request_n_i);
        if (acyc && command_bus_i[CMD_WRITE_BIT]) begin
          s_nxt.wr_pend = 1'b1;
        end else if (dcyc && s_r.wr_pend) begin
          // any address lands on the interrupt inputs
          s_nxt.wr_pend = 1'b0;
          s_nxt.iwr = 1'b1;
          s_nxt.idata = addr_data_bus_i;
        end else if (dcyc && s_r.rd_pend) begin
          s_nxt.rsp_v = 1'b1;
          s_nxt.rsp_d = addr_data_bus_i;
          s_nxt.rsp_last = last;
          s_nxt.err = s_r.err | command_bus_i[ID_ERR_BIT];
          if (last) begin
            s_nxt.rd_pend = 1'b0;
            s_nxt.err = 1'b0;
            s_nxt.berr = s_r.err | command_bus_i[ID_ERR_BIT];
            if (agent_bus_request_n_i) begin
              s_nxt.state = ST_MASTER;
              s_nxt.owns_n = 1'b0;
              s_nxt.ad_oe = 1'b1;
              s_nxt.cmd_oe = 1'b1;
              s_nxt.cmd = CMD_IDLE;
            end
          end
        end else if (!s_r.rd_pend && !s_r.wr_pend && agent_bus_request_n_i) begin
          s_nxt.state = ST_RETAKE;
          s_nxt.gap = 2'(RETAKE_CYC - RETAKE_CYC);
        end
      end
      ST_RETAKE: begin
        if (s_r.gap != NO_IDLE) begin
          s_nxt.gap = 2'(s_r.gap - ONE2);
        end else begin
          s_nxt.state = ST_MASTER;
          s_nxt.owns_n = 1'b0;
          s_nxt.ad_oe = 1'b1;
          s_nxt.cmd_oe = 1'b1;
          s_nxt.cmd = CMD_IDLE;
        end
      end
      default: begin
        s_nxt.state = ST_MASTER;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s_r <= '0;
      s_r.state <= ST_MASTER;
      s_r.ad_oe <= 1'b1;
      s_r.cmd_oe <= 1'b1;
      s_r.proc_valid_n_n <= 1'b1;
      s_r.proc_bus_request_n_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign addr_data_bus_o = s_r.ad;
  assign addr_data_bus_oe_o = s_r.ad_oe;
  assign command_bus_o = s_r.cmd;
  assign command_bus_oe_o = s_r.cmd_oe;
  assign proc_valid_n_o = s_r.proc_valid_n_n;
  assign proc_owns_bus_n_o = s_r.owns_n;
  assign proc_bus_request_n_o = s_r.proc_bus_request_n_n;
  assign req_ack_o = s_r.ack;
  assign rsp_valid_o = s_r.rsp_v;
  assign rsp_data_o = s_r.rsp_d;
  assign rsp_last_o = s_r.rsp_last;
  assign bus_error_o = s_r.berr;
  assign intr_write_o = s_r.iwr;
  assign intr_data_o = s_r.idata;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  logic slv_rd;
  assign slv_rd = (s_r.state == ST_SLAVE) && s_r.rd_pend && dcyc && !s_r.wr_pend;

  addr_cycle_a: assert property ((s_r.state == ST_ADDR) |-> !proc_valid_n_o
    && !command_bus_o[CMD_DATA_BIT] && command_bus_oe_o && addr_data_bus_oe_o)
    else $error("address cycle not driven");
  one_read_a: assert property ((s_r.state == ST_ADDR) |-> !s_r.rd_pend)
    else $error("second read started");
  read_release_a: assert property ((s_r.state == ST_ADDR && s_r.rdy_prev && rdy
    && !command_bus_o[CMD_WRITE_BIT]) |=> proc_owns_bus_n_o && !addr_data_bus_oe_o)
    else $error("bus not released after read");
  intr_write_a: assert property ((s_r.state == ST_SLAVE && s_r.wr_pend && dcyc)
    |=> intr_write_o && intr_data_o == $past(addr_data_bus_i))
    else $error("external write missed");
  resume_a: assert property ((slv_rd && last && agent_bus_request_n_i)
    |=> !proc_owns_bus_n_o) else $error("no resume after last word");
  stay_slave_a: assert property ((slv_rd && last && !agent_bus_request_n_i)
    |=> proc_owns_bus_n_o [*2]) else $error("took bus while agent holds it");
  bus_err_a: assert property ((slv_rd && last && command_bus_i[ID_ERR_BIT])
    |=> bus_error_o) else $error("bus error not raised");
  repeat_addr_a: assert property ((s_r.state == ST_ADDR && !rdy
    && agent_bus_request_n_i) |=> s_r.state == ST_ADDR && !proc_valid_n_o)
    else $error("address cycle not repeated");
  issue_two_a: assert property (req_ack_o |-> $past(rdy, 1) && $past(rdy, 2))
    else $error("issued without two ready cycles");
  accept_a: assert property (slv_rd |=> rsp_valid_o)
    else $error("response word dropped");
  dxx_idle_a: assert property ((s_r.state == ST_WDATA && !proc_valid_n_o
    && proc_tx_rate_field_i == RATE_DXX) |=> proc_valid_n_o [*2]
    ##0 $stable(addr_data_bus_o)) else $error("dxx idle cycles broken");
  retake_a: assert property ((s_r.state == ST_SLAVE && !s_r.rd_pend
    && !s_r.wr_pend && !acyc && !dcyc && agent_bus_request_n_i)
    |=> proc_owns_bus_n_o ##1 !proc_owns_bus_n_o) else $error("retake timing wrong");

  read_done_c: cover property (slv_rd && last);
  write_issue_c: cover property (req_ack_o && command_bus_o[CMD_WRITE_BIT]);
  ext_write_c: cover property (intr_write_o);
  killed_c: cover property (s_r.state == ST_ADDR && s_r.rdy_prev && !rdy);
endmodule // sysbus_flow

// ===== sysbus_pkg.sv
// shared constants and types for the system bus transaction logic
package sysbus_pkg;
  localparam int AD_W = 32;
  localparam int CMD_W = 5;
  localparam int CNT_W = 4;
  localparam int FIFO_DEPTH = 16;
  // command bus field positions
  localparam int CMD_DATA_BIT = 4;
  localparam int CMD_WRITE_BIT = 3;
  localparam int CMD_BLOCK_BIT = 2;
  localparam int ID_MORE_BIT = 3;
  localparam int ID_NOTRSP_BIT = 2;
  localparam int ID_ERR_BIT = 1;
  // processor data identifiers: good data, checking disabled
  localparam logic [CMD_W-1:0] ID_MORE = 5'h19;
  localparam logic [CMD_W-1:0] ID_LAST = 5'h11;
  localparam logic [CMD_W-1:0] CMD_IDLE = 5'h00;
  // block size codes
  localparam logic [1:0] BLK_2 = 2'h0;
  localparam logic [1:0] BLK_4 = 2'h1;
  localparam logic [CNT_W-1:0] WORDS_1 = 4'h1;
  localparam logic [CNT_W-1:0] WORDS_2 = 4'h2;
  localparam logic [CNT_W-1:0] WORDS_4 = 4'h4;
  localparam logic [CNT_W-1:0] WORDS_8 = 4'h8;
  // outgoing rate patterns
  localparam logic RATE_D = 1'b0;
  localparam logic RATE_DXX = 1'b1;
  localparam logic [1:0] DXX_IDLE = 2'h2;
  localparam logic [1:0] NO_IDLE = 2'h0;
  // bus taken back this many cycles after the agent request drops
  localparam logic [1:0] RETAKE_CYC = 2'h2;
  localparam logic [1:0] ONE2 = 2'h1;
  typedef enum logic [2:0] {
    ST_MASTER = 3'b000,
    ST_ADDR = 3'b001,
    ST_WDATA = 3'b010,
    ST_SLAVE = 3'b011,
    ST_RETAKE = 3'b100
  } bus_state_t;
endpackage

// ===== word_fifo.sv
// synchronous word fifo with valid/ready on both sides
`timescale 1ns/100ps
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r, cnt_nxt;
  logic room_r;
  logic push, pop;
  // registered so the fill side sees a flop, not a compare
  assign in_ready_o = room_r;
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign cnt_nxt = (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      room_r <= 1'b1;
    end else begin
      if (push) begin
        wp_r <= AW'(wp_r + 1'b1);
      end
      if (pop) begin
        rp_r <= AW'(rp_r + 1'b1);
      end
      cnt_r <= cnt_nxt;
      room_r <= (cnt_nxt != DEPTH[AW:0]);
    end
  end
endmodule // word_fifo

// ===== sysbus_agent.sv
// far-side agent model: answers reads, issues external writes, paces its data
`timescale 1ns/100ps
module sysbus_agent (
  // clock
  input wire logic mclk_i,
  // processor drive and ownership
  input wire logic proc_owns_bus_n_i,
  input wire logic ad_oe_i,
  input wire logic [sysbus_pkg::AD_W-1:0] ad_proc_i,
  input wire logic cmd_oe_i,
  input wire logic [sysbus_pkg::CMD_W-1:0] cmd_proc_i,
  // resolved bus and agent handshake
  output logic [sysbus_pkg::AD_W-1:0] ad_seen_o,
  output logic [sysbus_pkg::CMD_W-1:0] cmd_seen_o,
  output logic agent_valid_n_o,
  output logic agent_ready_n_o,
  output logic agent_bus_request_n_o
);
  import sysbus_pkg::*;
  logic [AD_W-1:0] ad_r = 32'h0;
  logic [CMD_W-1:0] cmd_r = 5'h00;
  logic busy_r = 1'b0;
  int stalls = 0;
  initial begin
    agent_valid_n_o = 1'b1;
    agent_ready_n_o = 1'b1;
    agent_bus_request_n_o = 1'b1;
  end
  // an undriven bus wanders so a stale word is never taken for data
  always @(posedge mclk_i) begin
    if (!busy_r) begin
      ad_r <= ~ad_r;
      cmd_r <= ~cmd_r;
    end
  end
  assign ad_seen_o = ad_oe_i ? ad_proc_i : ad_r;
  assign cmd_seen_o = cmd_oe_i ? cmd_proc_i : cmd_r;
  task automatic drive(input logic [CMD_W-1:0] c, input logic [AD_W-1:0] d);
    @(posedge mclk_i) #1;
    busy_r = 1'b1;
    cmd_r = c;
    ad_r = d;
    agent_valid_n_o = 1'b0;
  endtask
  task automatic set_ready(input logic v);
    agent_ready_n_o = v;
  endtask
  task automatic set_request(input logic v);
    agent_bus_request_n_o = v;
  endtask
  task automatic rest(input int n);
    repeat (n) begin
      @(posedge mclk_i) #1;
      agent_valid_n_o = 1'b1;
      busy_r = 1'b0;
    end
  endtask
  // the agent waits up to 30 cycles for the processor to let go of the bus, then talks anyway and counts a stall
  task automatic await_slave();
    for (int i = 0; i < 30 && proc_owns_bus_n_i !== 1'b1; i++) @(posedge mclk_i);
    if (proc_owns_bus_n_i !== 1'b1) stalls++;
  endtask
  task automatic ext_write(input logic [AD_W-1:0] d);
    await_slave();
    drive(5'h0b, 32'hffff_fff0);
    drive(5'h15, d);
  endtask
  task automatic respond(input int n, input logic [7:0] err, input logic [AD_W-1:0] base,
                         input int gap);
    await_slave();
    for (int i = 0; i < n; i++) begin
      drive({1'b1, i != n - 1, 1'b0, err[i], 1'b1}, base + 32'(i));
      if (i < n - 1) rest(gap);
    end
    rest(1);
  endtask
endmodule // sysbus_agent

// ===== test_system_bus_read_write_flow.sv
// self-checking bench for the system bus transaction logic
`timescale 1ns/100ps
module test_system_bus_read_write_flow;
  import sysbus_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [AD_W-1:0] ad_o, ad_seen, req_addr, wr_d, rsp_d, intr_d;
  logic [CMD_W-1:0] cmd_o, cmd_seen;
  logic [3:0] req_cmd;
  logic ad_oe, cmd_oe, proc_valid_n_n, owns_n, proc_bus_request_n_n, agent_valid_n_n, erdy_n, agent_bus_request_n_n, rate;
  logic req_valid, req_ack, wr_valid, wr_ready, rsp_valid, rsp_last, bus_err, intr_w;
  logic err_seen;
  int last_cnt;
  int miscompares = 0;
  int checks_done = 0;
  logic [AD_W-1:0] rsp_q[$];
  logic [AD_W-1:0] intr_q[$];
  sysbus_flow dut (.mclk_i(mclk), .reset_i(reset), .addr_data_bus_i(ad_seen),
    .addr_data_bus_o(ad_o), .addr_data_bus_oe_o(ad_oe), .command_bus_i(cmd_seen),
    .command_bus_o(cmd_o), .command_bus_oe_o(cmd_oe), .proc_valid_n_o(proc_valid_n_n),
    .proc_owns_bus_n_o(owns_n), .proc_bus_request_n_o(proc_bus_request_n_n), .agent_valid_n_i(agent_valid_n_n),
    .agent_ready_n_i(erdy_n), .agent_bus_request_n_i(agent_bus_request_n_n), .proc_tx_rate_field_i(rate),
    .req_valid_i(req_valid), .req_cmd_i(req_cmd), .req_addr_i(req_addr), .req_ack_o(req_ack),
    .wr_valid_i(wr_valid), .wr_ready_o(wr_ready), .wr_data_i(wr_d), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_d), .rsp_last_o(rsp_last), .bus_error_o(bus_err),
    .intr_write_o(intr_w), .intr_data_o(intr_d));
  sysbus_agent agent (.mclk_i(mclk), .proc_owns_bus_n_i(owns_n), .ad_oe_i(ad_oe),
    .ad_proc_i(ad_o), .cmd_oe_i(cmd_oe), .cmd_proc_i(cmd_o), .ad_seen_o(ad_seen),
    .cmd_seen_o(cmd_seen), .agent_valid_n_o(agent_valid_n_n), .agent_ready_n_o(erdy_n),
    .agent_bus_request_n_o(agent_bus_request_n_n));
  initial begin
    forever #2 mclk = ~mclk;
  end
  // pulses last one cycle, so they are gathered here and judged afterwards
  always @(negedge mclk) begin
    if (rsp_valid === 1'b1) begin
      rsp_q.push_back(rsp_d);
      last_cnt += int'(rsp_last);
      err_seen = err_seen | bus_err;
    end
    if (intr_w === 1'b1) intr_q.push_back(intr_d);
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick();
    @(posedge mclk) #1;
  endtask
  task automatic clear();
    rsp_q.delete();
    intr_q.delete();
    last_cnt = 0;
    err_seen = 1'b0;
  endtask
  // bit i of pat is the agent_ready_n_o level driven after edge i of the request
  task automatic issue(input logic [3:0] c, input logic [31:0] a, input logic [15:0] pat);
    int want;
    int i;
    want = 0;
    for (int j = 2; j < 15 && want == 0; j++) if (!pat[j-1] && !pat[j]) want = j + 1;
    req_valid = 1'b1;
    req_cmd = c;
    req_addr = a;
    i = 0;
    do begin
      tick();
      i++;
      if (req_ack !== 1'b1) begin
        chk("addr strobe", proc_valid_n_n, 1'b0);
        chk("addr cmd", cmd_o, {1'b0, c});
        chk("addr", ad_o, a);
        agent.set_ready(pat[i % 16]);
      end
    end while (req_ack !== 1'b1 && i < 20);
    req_valid = 1'b0;
    agent.set_ready(1'b1);
    chk("ack cycle", i, want);
    if (i == 20) report_and_stop();
  endtask
  task automatic write_out(input int n, input int step, input logic [31:0] base);
    int m;
    m = 0;
    for (int j = 0; j < (n - 1) * step + 1; j++) begin
      tick();
      if (j % step == 0) begin
        chk("data strobe", proc_valid_n_n, 1'b0);
        chk("data id", cmd_o, (m == n - 1) ? ID_LAST : ID_MORE);
        chk("data", ad_o, base + 32'(m));
        m++;
      end else begin
        chk("idle strobe", proc_valid_n_n, 1'b1);
        chk("held data", ad_o, base + 32'(m - 1));
      end
    end
    tick();
    chk("strobe after data", proc_valid_n_n, 1'b1);
  endtask
  task automatic read_single();
    clear();
    issue(4'h3, 32'h0000_1000, 16'h001e);
    chk("owns after read", owns_n, 1'b1);
    chk("bus released", ad_oe, 1'b0);
    chk("cmd released", cmd_oe, 1'b0);
    tick();
    req_valid = 1'b1;
    repeat (4) begin
      tick();
      chk("second read held", proc_valid_n_n, 1'b1);
    end
    req_valid = 1'b0;
    agent.respond(1, 8'h00, 32'h5a5a_0000, 0);
    tick();
    chk("single word", rsp_q.size(), 1);
    chk("single data", rsp_q[0], 32'h5a5a_0000);
    chk("single last", last_cnt, 1);
    chk("master again", owns_n, 1'b0);
  endtask
  task automatic read_block();
    clear();
    issue(4'h5, 32'h0000_3000, 16'h0000);
    agent.ext_write(32'hcafe_0001);
    agent.respond(4, 8'h02, 32'h4400_0000, 0);
    tick();
    chk("intr count", intr_q.size(), 1);
    chk("intr data", intr_q[0], 32'hcafe_0001);
    chk("block words", rsp_q.size(), 4);
    for (int k = 0; k < 4; k++) chk("block data", rsp_q[k], 32'h4400_0000 + 32'(k));
    chk("last flags", last_cnt, 1);
    chk("bus error", err_seen, 1'b1);
  endtask
  // fill the fifo until it refuses, then drain it at both rates with a stalling agent
  task automatic write_flow();
    int n;
    wr_valid = 1'b1;
    for (n = 0; n < 20 && wr_ready === 1'b1; n++) begin
      wr_d = 32'h7000_0000 + 32'(n);
      tick();
    end
    wr_valid = 1'b0;
    chk("fifo depth", n, 16);
    rate = RATE_D;
    issue(4'he, 32'h0000_6000, 16'h000c);
    write_out(8, 1, 32'h7000_0000);
    rate = RATE_DXX;
    issue(4'he, 32'h0000_6020, 16'h001e);
    write_out(8, 3, 32'h7000_0008);
    chk("fifo drained", wr_ready, 1'b1);
    // let the last dxx idle cycles run out before the next request
    repeat (2) tick();
    chk("idle after write", proc_valid_n_n, 1'b1);
  endtask
  task automatic hold_slave();
    clear();
    wr_valid = 1'b1;
    wr_d = 32'h0bad_f00d;
    tick();
    wr_valid = 1'b0;
    issue(4'h4, 32'h0000_4000, 16'h0000);
    agent.set_request(1'b0);
    agent.respond(2, 8'h00, 32'h3300_0000, 2);
    tick();
    chk("paced words", rsp_q.size(), 2);
    chk("no error", err_seen, 1'b0);
    chk("still slave", owns_n, 1'b1);
    req_valid = 1'b1;
    req_cmd = 4'hb;
    tick();
    tick();
    chk("own request", proc_bus_request_n_n, 1'b0);
    chk("no strobe", proc_valid_n_n, 1'b1);
    agent.set_request(1'b1);
    tick();
    chk("retake gap", owns_n, 1'b1);
    tick();
    chk("retaken", owns_n, 1'b0);
    chk("drives again", ad_oe, 1'b1);
    issue(4'hb, 32'h0000_5000, 16'h0000);
    write_out(1, 1, 32'h0bad_f00d);
  endtask
  initial begin
    {req_valid, wr_valid, rate, req_cmd, req_addr, wr_d} = '0;
    clear();
    repeat (12) @(posedge mclk);
    #1;
    reset = 1'b0;
    read_single();
    read_block();
    write_flow();
    hold_slave();
    chk("agent waits", agent.stalls, 32'h0);
    report_and_stop();
  end
endmodule // test_system_bus_read_write_flow
